// ---- hdl/ccb_defines.vh ----
/*
 * Constants for the call / clear / bit-test execution block:
 * opcode patterns, operand field positions and reset values.
 * Assumes 14-bit instruction words and a 13-bit program counter.
 */
`ifndef CCB_DEFINES_VH
`define CCB_DEFINES_VH

// Opcode match values (upper bits of the instruction word)
`define CCB_OP_BTSS_HI     4'h7
`define CCB_OP_CLEAR_HI    7'h03
`define CCB_OP_CALL_HI     3'h4
// Lowest bit of each opcode match field
`define CCB_OP_BTSS_LSB    10
`define CCB_OP_CLEAR_LSB   7
`define CCB_OP_CALL_LSB    11
// Operand field positions
`define CCB_F_ADDR_MSB     6
`define CCB_F_ADDR_LSB     0
`define CCB_F_BIT_MSB      9
`define CCB_F_BIT_LSB      7
`define CCB_F_K_MSB        10
`define CCB_F_K_LSB        0
`define CCB_LATH_HI_MSB    4
`define CCB_LATH_HI_LSB    3
// Reset values
`define CCB_PC_RST         13'h0000
`define CCB_INSN_NOP       14'h0000
`define CCB_ZERO_DATA      8'h00
`define CCB_FILE_ADDR_RST  7'h00

`endif

// ---- hdl/ccb_decode.v ----
/*
 * Combinational instruction decoder for the call / clear / bit-test
 * block. Pure logic; the caller registers everything it drives out.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ccb_defines.vh"

module ccb_decode #(
    parameter IW = 14
) (
    // Instruction word
    input  wire [IW-1:0] i_insn,
    // Decoded class and operands
    output wire          o_is_btss,
    output wire          o_is_clear,
    output wire          o_is_call,
    output wire [6:0]    o_faddr,
    output wire [2:0]    o_bitsel,
    output wire [10:0]   o_target
);

    // Opcode classes
    assign o_is_btss  = (i_insn[IW-1:`CCB_OP_BTSS_LSB] == `CCB_OP_BTSS_HI);
    assign o_is_clear = (i_insn[IW-1:`CCB_OP_CLEAR_LSB] == `CCB_OP_CLEAR_HI);
    assign o_is_call  = (i_insn[IW-1:`CCB_OP_CALL_LSB] == `CCB_OP_CALL_HI);

    // Operand fields
    assign o_faddr  = i_insn[`CCB_F_ADDR_MSB:`CCB_F_ADDR_LSB];
    assign o_bitsel = i_insn[`CCB_F_BIT_MSB:`CCB_F_BIT_LSB];
    assign o_target = i_insn[`CCB_F_K_MSB:`CCB_F_K_LSB];

endmodule
`default_nettype wire

// ---- hdl/ccb_exec.v ----
/*
 * Execution unit for bit_test_skip_when_set, clear_file_register and
 * subroutine call of an 8-bit core with 14-bit instruction words.
 * Assumes: the fetch stage presents one instruction per cycle with
 * a valid strobe; file register read data for the word's own address
 * arrives in the same cycle as the word; stack, file space and flags
 * live outside.
 * Limitation: a clear leaves its write a cycle after its word, so the
 * outer file logic must forward it to a bit test that directly follows.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ccb_defines.vh"

module ccb_exec #(
    parameter PCW = 13,
    parameter IW  = 14
) (
    // Clock and reset
    input  wire           i_clk,
    input  wire           i_rst_n,
    // Fetched instruction
    input  wire [IW-1:0]  i_insn,
    input  wire           i_insn_valid,
    input  wire [PCW-1:0] i_pc,
    // File register read data for the address field of i_insn
    input  wire [7:0]     i_file_rdata,
    // Program counter high latch register
    input  wire [7:0]     i_pc_high_latch,
    // File register write port
    output reg  [6:0]     o_file_addr,
    output reg            o_file_we,
    output reg  [7:0]     o_file_wdata,
    // Status zero flag set strobe
    output reg            o_zero_set,
    // Stack push
    output reg            o_stack_push,
    output reg  [PCW-1:0] o_top_of_stack,
    // Program counter load
    output reg            o_pc_load,
    output reg  [PCW-1:0] o_pc_target,
    // Fetch pipeline control
    output reg            o_flush,
    output reg            o_busy
);

    // ************************************************************
    // Reset synchroniser
    // ************************************************************
    reg rst_meta;
    reg rst_sync_n;

    // Async assert, two-flop release
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ************************************************************
    // Decode
    // ************************************************************
    wire        is_btss;
    wire        is_clear;
    wire        is_call;
    wire [6:0]  faddr;
    wire [2:0]  bitsel;
    wire [10:0] target;

    ccb_decode #(
        .IW (IW)
    ) u_dec (
        .i_insn    (i_insn),
        .o_is_btss (is_btss),
        .o_is_clear (is_clear),
        .o_is_call (is_call),
        .o_faddr   (faddr),
        .o_bitsel  (bitsel),
        .o_target  (target)
    );

    // Selected bit of the addressed file register
    function sel_bit;
        input [7:0] data;
        input [2:0] idx;
        begin
            sel_bit = data[idx];
        end
    endfunction

    // ************************************************************
    // Execute
    // ************************************************************
    // Second cycle of a call or taken skip: the prefetched word is
    // dead, so nothing in it may execute.
    reg  kill;
    wire live = i_insn_valid && !kill;

    reg            next_kill;
    reg            next_file_we;
    reg  [7:0]     next_file_wdata;
    reg            next_zero_set;
    reg            next_push;
    reg  [PCW-1:0] next_top_of_stack;
    reg            next_pc_load;
    reg  [PCW-1:0] next_pc_target;

    // Next-state logic for the three instructions
    always @* begin
        next_kill       = 1'b0;
        next_file_we    = 1'b0;
        next_file_wdata = `CCB_ZERO_DATA;
        next_zero_set   = 1'b0;
        next_push       = 1'b0;
        next_top_of_stack = o_top_of_stack;
        next_pc_load    = 1'b0;
        next_pc_target  = o_pc_target;
        if (live) begin
            if (is_btss && sel_bit(i_file_rdata, bitsel)) begin
                next_kill = 1'b1;
            end else if (is_clear) begin
                next_file_we    = 1'b1;
                next_file_wdata = `CCB_ZERO_DATA;
                next_zero_set   = 1'b1;
            end else if (is_call) begin
                next_push      = 1'b1;
                next_top_of_stack = i_pc + {{(PCW-1){1'b0}}, 1'b1};
                next_pc_load   = 1'b1;
                next_pc_target = {i_pc_high_latch[`CCB_LATH_HI_MSB:`CCB_LATH_HI_LSB],
                                  target};
                next_kill      = 1'b1;
            end
        end
    end

    // ************************************************************
    // Sequencing
    // ************************************************************
    // Kill marks the dead second cycle. It never stands two cycles in
    // a row, because a killed word can not start a new kill itself.
    always @(posedge i_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            kill <= 1'b0;
        end else begin
            kill <= next_kill;
        end
    end

    // ************************************************************
    // File register write port and zero flag
    // ************************************************************
    // Address follows every word so the outer file logic always sees
    // where the last word pointed; only the strobe qualifies it.
    always @(posedge i_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            o_file_addr  <= `CCB_FILE_ADDR_RST;
            o_file_we    <= 1'b0;
            o_file_wdata <= `CCB_ZERO_DATA;
            o_zero_set   <= 1'b0;
        end else begin
            o_file_addr  <= faddr;
            o_file_we    <= next_file_we;
            o_file_wdata <= next_file_wdata;
            o_zero_set   <= next_zero_set;
        end
    end

    // ************************************************************
    // Stack push
    // ************************************************************
    // Return address holds after the pulse; the stack only looks at
    // it while the push strobe is high.
    always @(posedge i_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            o_stack_push   <= 1'b0;
            o_top_of_stack <= `CCB_PC_RST;
        end else begin
            o_stack_push   <= next_push;
            o_top_of_stack <= next_top_of_stack;
        end
    end

    // ************************************************************
    // Program counter load
    // ************************************************************
    // Push and load share one cycle. The outer logic must apply the
    // push before the new value reaches the program counter, or the
    // stack would save the jump target instead of the return address.
    always @(posedge i_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            o_pc_load   <= 1'b0;
            o_pc_target <= `CCB_PC_RST;
        end else begin
            o_pc_load   <= next_pc_load;
            o_pc_target <= next_pc_target;
        end
    end

    // ************************************************************
    // Fetch pipeline control
    // ************************************************************
    // Flush and busy are one event seen from two sides: flush tells
    // fetch to drop its word, busy marks the inserted no-operation.
    always @(posedge i_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            o_flush <= 1'b0;
            o_busy  <= 1'b0;
        end else begin
            o_flush <= next_kill;
            o_busy  <= next_kill;
        end
    end

endmodule
`default_nettype wire

// ---- tb/ccb_exec_asserts.sv ----
/* Port checker for ccb_exec. Assumes 14-bit words, 13-bit PC, latency 1. */
`timescale 1ns/100ps
`default_nettype none
// ************
// Checker
// ************
module ccb_exec_chk (
    // Inputs of the block
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic [13:0] i_insn,
    input wire logic        i_insn_valid,
    input wire logic [12:0] i_pc,
    input wire logic [7:0]  i_file_rdata,
    input wire logic [7:0]  i_pc_high_latch,
    // Outputs of the block
    input wire logic [6:0]  o_file_addr,
    input wire logic        o_file_we,
    input wire logic [7:0]  o_file_wdata,
    input wire logic        o_zero_set,
    input wire logic        o_stack_push,
    input wire logic [12:0] o_top_of_stack,
    input wire logic        o_pc_load,
    input wire logic [12:0] o_pc_target,
    input wire logic        o_flush,
    input wire logic        o_busy
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // Taken word and its class; a busy cycle kills the word
    wire take = i_insn_valid && !o_busy;
    wire call = take && i_insn[13:11] == 3'h4;
    wire clr = take && i_insn[13:7] == 7'h03;
    wire bt = take && i_insn[13:10] == 4'h7;
    wire hit = i_file_rdata[i_insn[9:7]];
    AST_ADDR: assert property (clr |=> o_file_addr == $past(i_insn[6:0]))
        else $error("file address wrong");
    AST_SKIP: assert property (bt && hit |=> o_flush && o_busy ##1 !o_busy)
        else $error("skip not taken");
    AST_NOSKIP: assert property (bt && !hit |=> !o_flush && !o_busy)
        else $error("false skip");
    AST_CLR: assert property (clr |=> o_file_we && o_zero_set && o_file_wdata == 8'h00)
        else $error("clear wrong");
    AST_WE_CAUSE: assert property (o_file_we |-> $past(clr))
        else $error("stray write");
    AST_PUSH: assert property (call |=> o_stack_push && o_top_of_stack == $past(i_pc) + 13'h1)
        else $error("push wrong");
    AST_LOW: assert property (call |=> o_pc_load && o_pc_target[10:0] == $past(i_insn[10:0]))
        else $error("target low wrong");
    AST_HIGH: assert property (call |=> o_pc_target[12:11] == $past(i_pc_high_latch[4:3]))
        else $error("target high wrong");
    AST_TWO: assert property (call |=> o_busy && o_flush ##1 !o_busy)
        else $error("call not two cycles");
    AST_KILL: assert property (o_busy |=> !o_file_we && !o_stack_push && !o_pc_load)
        else $error("killed word acted");
    AST_COVER_CALL: cover property (call ##1 o_pc_load);
    AST_COVER_SKIP: cover property (bt && hit ##1 o_busy);
    AST_COVER_CLR: cover property (clr ##1 o_file_we);
endmodule
bind ccb_exec ccb_exec_chk u_chk (.*);
`default_nettype wire

// ---- tb/testbench.sv ----
/* Directed bench for ccb_exec. Assumes the checker is bound to the dut. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end
// ************
// Bench
// ************
module testbench;
    logic i_clk = 0, i_rst_n = 0, i_insn_valid = 0;
    logic [13:0] i_insn = 14'h0000;
    logic [12:0] i_pc = 13'h0000;
    logic [7:0] i_file_rdata = 8'h00, i_pc_high_latch = 8'h00;
    wire [6:0] o_file_addr;
    wire [7:0] o_file_wdata;
    wire [12:0] o_top_of_stack, o_pc_target;
    wire o_file_we, o_zero_set, o_stack_push, o_pc_load, o_flush, o_busy;
    int n_errors = 0, total_checks = 0;
    ccb_exec dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_insn(i_insn),
        .i_insn_valid(i_insn_valid), .i_pc(i_pc), .i_file_rdata(i_file_rdata),
        .i_pc_high_latch(i_pc_high_latch), .o_file_addr(o_file_addr),
        .o_file_we(o_file_we), .o_file_wdata(o_file_wdata), .o_zero_set(o_zero_set),
        .o_stack_push(o_stack_push), .o_top_of_stack(o_top_of_stack),
        .o_pc_load(o_pc_load), .o_pc_target(o_pc_target), .o_flush(o_flush),
        .o_busy(o_busy));
    // 50 MHz clock
    initial begin
        forever #10 i_clk = ~i_clk;
    end
    // One word, outputs judged a cycle later; gap cycle keeps it unkilled
    task ex(input logic [13:0] w, input logic [7:0] rd);
        @(negedge i_clk);
        i_insn = w;
        i_file_rdata = rd;
        i_insn_valid = 1;
        @(negedge i_clk);
        i_insn_valid = 0;
    endtask
    // Clear at both address limits
    task t_clear;
        for (int f = 0; f < 128; f += 127) begin
            ex(14'h0180 | f[13:0], 8'h5A);
            `CHK(o_file_we & o_zero_set, 1'h1);
            `CHK(o_busy, 1'h0);
            `CHK(o_file_wdata, 8'h00);
            `CHK(o_file_addr, f[6:0]);
        end
    endtask
    // Every bit select, set and clear
    task t_skip;
        for (int b = 0; b < 8; b++) begin
            ex(14'h1C00 | (b[13:0] << 7) | 14'h0005, 8'h01 << b);
            `CHK({o_flush, o_busy}, 2'h3);
            ex(14'h1C00 | (b[13:0] << 7) | 14'h0005, ~(8'h01 << b));
            `CHK({o_flush, o_busy}, 2'h0);
        end
    endtask
    // Call across a carry, then a clear offered in the killed cycle
    task t_call(input logic [7:0] lat, input logic [10:0] k);
        @(negedge i_clk);
        i_pc = 13'h07FF;
        i_pc_high_latch = lat;
        i_insn = 14'h2000 | {3'h0, k};
        i_file_rdata = 8'h00;
        i_insn_valid = 1;
        @(negedge i_clk);
        i_insn = 14'h0185;
        `CHK(o_stack_push & o_pc_load, 1'h1);
        `CHK(o_top_of_stack, 13'h0800);
        `CHK(o_pc_target[10:0], k);
        `CHK(o_pc_target[12:11], lat[4:3]);
        `CHK(o_busy & o_flush, 1'h1);
        @(negedge i_clk);
        i_insn_valid = 0;
        `CHK({o_file_we, o_zero_set, o_stack_push, o_busy}, 4'h0);
    endtask
    task tally_and_finish;
        if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog
    initial begin
        #40000;
        n_errors++;
        tally_and_finish;
    end
    // Main sequence
    initial begin
        repeat (3) @(negedge i_clk);
        i_rst_n = 1;
        repeat (3) @(negedge i_clk);
        t_clear;
        t_skip;
        t_call(8'h18, 11'h7FF);
        t_call(8'hE7, 11'h2AA);
        tally_and_finish;
    end
endmodule
`default_nettype wire
